/* irq_combine.sv */
// Purpose: Forms the single level interrupt request.
// Assumes: Flags and enables are on the same clock.
// Notes: Output is registered, so it lags its causes by one cycle.
`timescale 1ns/1ps
`default_nettype none

module irq_combine #(
    parameter int FLAGS = 4,
    parameter int EVENTS = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [FLAGS-1:0] flag_i,
    input wire logic [FLAGS-1:0] enable_i,
    input wire logic [EVENTS-1:0] evt_i,
    input wire logic [EVENTS-1:0] mask_i,
    output logic irq_o
);

    logic irq_reg;
    logic irq_next;

    // Level request: stays up while any enabled flag or event holds.
    assign irq_next = |(flag_i & enable_i) | |(evt_i & mask_i);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= irq_next;
    end

    assign irq_o = irq_reg;

endmodule

`default_nettype wire

/* pin_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to CLK_I.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_reg <= IDLE;
            sync_reg <= IDLE;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

`default_nettype wire

/* remote_serial.sv */
// Purpose: Remote serial device on the transmit and receive lines.
// Assumes: One start bit, eight data bits lsb first, one stop bit.
// Notes: Both lines idle high through their pull-ups when undriven.
`timescale 1ns/1ps
`default_nettype none

module remote_serial #(
    parameter int BIT_CYC = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic [7:0] data_i,
    input wire logic shared_i,
    input wire logic txd_i,
    input wire logic txd_oe_i,
    output logic txd_line_o,
    output logic rxd_line_o
);
    logic [9:0] frame;
    logic [3:0] bits;
    int cnt;
    logic tx_bit;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            frame <= '1;
            bits <= 4'h0;
            cnt <= 0;
        end
        else if (send_i && bits == 4'h0)
        begin
            frame <= {1'b1, data_i, 1'b0};
            bits <= 4'hA;
            cnt <= BIT_CYC - 1;
        end
        else if (bits != 4'h0)
        begin
            if (cnt == 0)
            begin
                frame <= {1'b1, frame[9:1]};
                bits <= bits - 4'h1;
                cnt <= BIT_CYC - 1;
            end
            else
                cnt <= cnt - 1;
        end
    end

    assign tx_bit = (bits != 4'h0) ? frame[0] : 1'b1;
    // In single-wire mode the remote talks on the shared line instead.
    assign rxd_line_o = shared_i ? 1'b1 : tx_bit;
    // The transceiver wins the shared line only while it enables it.
    assign txd_line_o = txd_oe_i ? txd_i : (shared_i ? tx_bit : 1'b1);
endmodule

`default_nettype wire

/* uart_ctrl_defines.svh */
// Purpose: Register indices, field positions and reset values.
// Assumes: Byte address of a register is four times its index.
// Notes: Included by the control block and its helpers.
`ifndef UART_CTRL_DEFINES_SVH
`define UART_CTRL_DEFINES_SVH

`define ADDR_W 8
`define IDX_W 6

`define IDX_CTRL_ONE 6'h02
`define IDX_CTRL_TWO 6'h03
`define IDX_STATUS_ONE 6'h04
`define IDX_CTRL_THREE 6'h06
`define IDX_EVT_STATUS 6'h07
`define IDX_EVT_MASK 6'h08

`define C2_TX_EMPTY_IE 7
`define C2_TX_COMPLETE_IE 6
`define C2_RX_FULL_IE 5
`define C2_IDLE_LINE_IE 4
`define C2_TX_ENABLE 3
`define C2_RX_ENABLE 2
`define C2_RX_STANDBY 1
`define C2_SEND_BREAK 0

`define C1_LOOP_SELECT 7
`define C1_RX_SOURCE 5
`define C3_SW_DIRECTION 5

`define S1_TX_EMPTY 7
`define S1_TX_COMPLETE 6
`define S1_RX_FULL 5
`define S1_IDLE_LINE 4

`define EV_IDLE_QUEUED 0
`define EV_WAKE 1
`define EV_TX_RELEASED 2
`define EV_W 3

`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_CTRL_THREE 8'h00
`define RST_EVT 3'h0

`endif

/* uart_ctrl_pkg.sv */
// Purpose: Types shared by the transceiver control block.
// Assumes: Nothing beyond the defines header.
// Notes: State codes are one-hot.
`include "uart_ctrl_defines.svh"

package uart_ctrl_pkg;

    typedef enum logic [2:0] {
        TX_OFF = 3'b001,
        TX_ON = 3'b010,
        TX_DRAIN = 3'b100
    } tx_state_t;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] ctrl_three;
        logic [`EV_W-1:0] evt;
        logic [`EV_W-1:0] mask;
        tx_state_t tx_state;
        logic cleared_busy;
        logic idle_pulse;
        logic [31:0] prdata;
        logic pslverr;
        logic pin_out;
        logic pin_oe;
        logic rx_serial;
    } ctrl_state_t;

endpackage

/* uart_tx_rx_control.sv */
// Purpose: Control register logic of the serial transceiver.
// Assumes: Flags, busy and serial data come from logic on CLK_I.
// Notes: APB slave with zero wait states; pins pass a synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_defines.svh"

module uart_tx_rx_control (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic TX_EMPTY_FLAG_I,
    input wire logic TX_COMPLETE_FLAG_I,
    input wire logic RX_FULL_FLAG_I,
    input wire logic IDLE_FLAG_I,
    input wire logic TX_BUSY_I,
    input wire logic TX_SERIAL_I,
    input wire logic WAKE_EVENT_I,
    input wire logic TXD_PIN_I,
    input wire logic RXD_PIN_I,
    output logic TXD_PIN_O,
    output logic TXD_PIN_OE_O,
    output logic TXD_OWNED_O,
    output logic RXD_OWNED_O,
    output logic RX_SERIAL_O,
    output logic TX_ENABLE_O,
    output logic RX_ENABLE_O,
    output logic RX_STANDBY_O,
    output logic SEND_BREAK_O,
    output logic QUEUE_IDLE_O,
    output logic IRQ_O
);
    import uart_ctrl_pkg::*;

    localparam ctrl_state_t ST_RST = '{
        ctrl_one: `RST_CTRL_ONE,
        ctrl_two: `RST_CTRL_TWO,
        ctrl_three: `RST_CTRL_THREE,
        evt: `RST_EVT,
        mask: `RST_EVT,
        tx_state: TX_OFF,
        cleared_busy: 1'b0,
        idle_pulse: 1'b0,
        prdata: 32'h0000_0000,
        pslverr: 1'b0,
        pin_out: 1'b1,
        pin_oe: 1'b0,
        rx_serial: 1'b1
    };

    ctrl_state_t s;
    ctrl_state_t ns;

    logic [`IDX_W-1:0] idx;
    logic [1:0] pins_sync;
    logic txd_sync;
    logic rxd_sync;
    logic wr_en;
    logic wr_two;
    logic loop_sel;
    logic single_wire;
    logic tx_en;
    logic rx_en;
    logic [3:0] flags;
    logic [3:0] flag_en;
    logic [7:0] status_one;

    function automatic logic is_mapped(input logic [`IDX_W-1:0] i);
        case (i)
            `IDX_CTRL_ONE,
            `IDX_CTRL_TWO,
            `IDX_STATUS_ONE,
            `IDX_CTRL_THREE,
            `IDX_EVT_STATUS,
            `IDX_EVT_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    pin_sync #(
        .WIDTH(2),
        .IDLE(2'h3)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .async_i({TXD_PIN_I, RXD_PIN_I}),
        .sync_o(pins_sync)
    );

    assign txd_sync = pins_sync[1];
    assign rxd_sync = pins_sync[0];

    assign idx = PADDR_I[`ADDR_W-1:2];
    // Access is never refused by state; only unmapped words error.
    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0]
        & is_mapped(idx);
    assign wr_two = wr_en & (idx == `IDX_CTRL_TWO);

    assign loop_sel = s.ctrl_one[`C1_LOOP_SELECT];
    assign single_wire = loop_sel & s.ctrl_one[`C1_RX_SOURCE];
    assign tx_en = s.ctrl_two[`C2_TX_ENABLE];
    assign rx_en = s.ctrl_two[`C2_RX_ENABLE];

    assign flags = {TX_EMPTY_FLAG_I, TX_COMPLETE_FLAG_I,
        RX_FULL_FLAG_I, IDLE_FLAG_I};
    assign flag_en = s.ctrl_two[`C2_TX_EMPTY_IE:`C2_IDLE_LINE_IE];

    always_comb
    begin
        status_one = 8'h00;
        status_one[`S1_TX_EMPTY] = TX_EMPTY_FLAG_I;
        status_one[`S1_TX_COMPLETE] = TX_COMPLETE_FLAG_I;
        status_one[`S1_RX_FULL] = RX_FULL_FLAG_I;
        status_one[`S1_IDLE_LINE] = IDLE_FLAG_I;
    end

    always_comb
    begin
        ns = s;
        ns.idle_pulse = 1'b0;

        // Read data is latched in the setup cycle, so the access phase
        // can complete at once.
        if (PSEL_I && !PENABLE_I)
        begin
            ns.pslverr = !is_mapped(idx);
            case (idx)
                `IDX_CTRL_ONE: ns.prdata = {24'h000000, s.ctrl_one};
                `IDX_CTRL_TWO: ns.prdata = {24'h000000, s.ctrl_two};
                `IDX_STATUS_ONE: ns.prdata = {24'h000000, status_one};
                `IDX_CTRL_THREE: ns.prdata = {24'h000000, s.ctrl_three};
                `IDX_EVT_STATUS: ns.prdata = {29'h00000000, s.evt};
                `IDX_EVT_MASK: ns.prdata = {29'h00000000, s.mask};
                default: ns.prdata = 32'h0000_0000;
            endcase
        end

        // Hardware wake clears standby; a write of one in the same
        // cycle is applied afterwards and wins.
        if (WAKE_EVENT_I && s.ctrl_two[`C2_RX_STANDBY])
        begin
            ns.ctrl_two[`C2_RX_STANDBY] = 1'b0;
            ns.evt[`EV_WAKE] = 1'b1;
        end

        if (!TX_BUSY_I)
            ns.cleared_busy = 1'b0;

        if (wr_en)
        begin
            case (idx)
                `IDX_CTRL_ONE: ns.ctrl_one = PWDATA_I[7:0];
                `IDX_CTRL_TWO: ns.ctrl_two = PWDATA_I[7:0];
                `IDX_CTRL_THREE: ns.ctrl_three = PWDATA_I[7:0];
                `IDX_EVT_STATUS: ns.evt = s.evt & ~PWDATA_I[`EV_W-1:0];
                `IDX_EVT_MASK: ns.mask = PWDATA_I[`EV_W-1:0];
                default: ns.mask = s.mask;
            endcase
        end

        if (wr_two && tx_en && !PWDATA_I[`C2_TX_ENABLE] && TX_BUSY_I)
            ns.cleared_busy = 1'b1;
        // Re-enabling during the same transmission queues an idle.
        if (wr_two && !tx_en && PWDATA_I[`C2_TX_ENABLE]
            && s.cleared_busy && TX_BUSY_I)
        begin
            ns.idle_pulse = 1'b1;
            ns.cleared_busy = 1'b0;
        end

        case (s.tx_state)
            TX_OFF:
            begin
                if (tx_en)
                    ns.tx_state = TX_ON;
            end
            TX_ON:
            begin
                if (!tx_en)
                    ns.tx_state = TX_DRAIN;
            end
            TX_DRAIN:
            begin
                // Hold the pin while data, idle or break remain.
                if (tx_en)
                    ns.tx_state = TX_ON;
                else if (!TX_BUSY_I && !s.idle_pulse
                    && !s.ctrl_two[`C2_SEND_BREAK])
                begin
                    ns.tx_state = TX_OFF;
                    ns.evt[`EV_TX_RELEASED] = 1'b1;
                end
            end
            default: ns.tx_state = TX_OFF;
        endcase

        // Event sets come last so they win over a clear.
        if (s.idle_pulse)
            ns.evt[`EV_IDLE_QUEUED] = 1'b1;
        if (WAKE_EVENT_I && s.ctrl_two[`C2_RX_STANDBY])
            ns.evt[`EV_WAKE] = 1'b1;
        if (s.tx_state == TX_DRAIN && ns.tx_state == TX_OFF)
            ns.evt[`EV_TX_RELEASED] = 1'b1;

        ns.pin_out = (ns.tx_state == TX_OFF) ? 1'b1 : TX_SERIAL_I;
        // In single-wire mode a clear direction bit turns the driver off.
        ns.pin_oe = (ns.tx_state != TX_OFF)
            && !(single_wire && !s.ctrl_three[`C3_SW_DIRECTION]);

        if (!rx_en)
            ns.rx_serial = 1'b1;
        else if (single_wire)
            ns.rx_serial = txd_sync;
        else if (loop_sel)
            ns.rx_serial = TX_SERIAL_I;
        else
            ns.rx_serial = rxd_sync;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            s <= ST_RST;
        else
            s <= ns;
    end

    irq_combine #(
        .FLAGS(4),
        .EVENTS(`EV_W)
    ) u_irq_combine (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .flag_i(flags),
        .enable_i(flag_en),
        .evt_i(s.evt),
        .mask_i(s.mask),
        .irq_o(IRQ_O)
    );

    assign PRDATA_O = s.prdata;
    assign PREADY_O = PSEL_I & PENABLE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & s.pslverr;
    assign TXD_PIN_O = s.pin_out;
    assign TXD_PIN_OE_O = s.pin_oe;
    assign TXD_OWNED_O = (s.tx_state != TX_OFF);
    assign RXD_OWNED_O = rx_en & !loop_sel;
    assign RX_SERIAL_O = s.rx_serial;
    assign TX_ENABLE_O = tx_en;
    assign RX_ENABLE_O = rx_en;
    assign RX_STANDBY_O = s.ctrl_two[`C2_RX_STANDBY];
    assign SEND_BREAK_O = s.ctrl_two[`C2_SEND_BREAK];
    assign QUEUE_IDLE_O = s.idle_pulse;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    property p_tx_empty_irq;
        (TX_EMPTY_FLAG_I && s.ctrl_two[`C2_TX_EMPTY_IE]) |=> IRQ_O;
    endproperty
    a_tx_empty_irq: assert property (p_tx_empty_irq)
        else $error("Tx empty interrupt missing.");

    property p_tx_complete_irq;
        (TX_COMPLETE_FLAG_I && s.ctrl_two[`C2_TX_COMPLETE_IE]) |=> IRQ_O;
    endproperty
    a_tx_complete_irq: assert property (p_tx_complete_irq)
        else $error("Tx complete interrupt missing.");

    property p_rx_full_irq;
        (RX_FULL_FLAG_I && s.ctrl_two[`C2_RX_FULL_IE]) |=> IRQ_O;
    endproperty
    a_rx_full_irq: assert property (p_rx_full_irq)
        else $error("Rx full interrupt missing.");

    property p_idle_irq;
        (IDLE_FLAG_I && s.ctrl_two[`C2_IDLE_LINE_IE]) |=> IRQ_O;
    endproperty
    a_idle_irq: assert property (p_idle_irq)
        else $error("Idle line interrupt missing.");

    property p_irq_quiet;
        !(|(flags & flag_en)) && !(|(s.evt & s.mask)) |=> !IRQ_O;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("Interrupt raised with no enabled cause.");

    property p_tx_owns_pin;
        $rose(tx_en) |=> TXD_OWNED_O ##0 (TXD_PIN_OE_O || single_wire);
    endproperty
    a_tx_owns_pin: assert property (p_tx_owns_pin)
        else $error("Transmit pin not taken on enable.");

    property p_sw_input;
        (single_wire && !s.ctrl_three[`C3_SW_DIRECTION]) |=> !TXD_PIN_OE_O;
    endproperty
    a_sw_input: assert property (p_sw_input)
        else $error("Pin driven in single-wire input direction.");

    property p_queue_idle;
        (wr_two && !tx_en && PWDATA_I[`C2_TX_ENABLE] && s.cleared_busy
            && TX_BUSY_I) |=> QUEUE_IDLE_O ##1 !QUEUE_IDLE_O;
    endproperty
    a_queue_idle: assert property (p_queue_idle)
        else $error("Idle character not queued.");

    property p_drain_hold;
        (TXD_OWNED_O && TX_BUSY_I) |=> TXD_OWNED_O;
    endproperty
    a_drain_hold: assert property (p_drain_hold)
        else $error("Transmit pin released while busy.");

    property p_rx_off;
        !rx_en |=> RX_SERIAL_O && !$past(RXD_OWNED_O);
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("Receiver active while disabled.");

    property p_loop_pin;
        loop_sel |-> !RXD_OWNED_O;
    endproperty
    a_loop_pin: assert property (p_loop_pin)
        else $error("Receive pin held in loop mode.");

    property p_c2_write;
        wr_two |=> s.ctrl_two == $past(PWDATA_I[7:0]);
    endproperty
    a_c2_write: assert property (p_c2_write)
        else $error("Control write not stored.");

    property p_wake;
        (WAKE_EVENT_I && RX_STANDBY_O && !wr_two) |=> !RX_STANDBY_O;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Standby not left on wake.");

    property p_internal_loop;
        (loop_sel && !single_wire && rx_en)
            |=> RX_SERIAL_O == $past(TX_SERIAL_I);
    endproperty
    a_internal_loop: assert property (p_internal_loop)
        else $error("Internal loopback path broken.");

    c_queue_idle: cover property (QUEUE_IDLE_O);
    c_release: cover property (s.tx_state == TX_DRAIN ##1 !TXD_OWNED_O);
    c_wake: cover property (RX_STANDBY_O ##1 !RX_STANDBY_O);
    c_irq: cover property ($rose(IRQ_O));

endmodule

`default_nettype wire

/* uart_tx_rx_control_tb.sv */
// Purpose: Self-checking bench for the transceiver control block.
// Assumes: APB slave answers when it raises pready.
// Notes: Core flags, busy and serial data are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_defines.svh"

module uart_tx_rx_control_tb;
    localparam logic [7:0] A_C1 = {`IDX_CTRL_ONE, 2'b00};
    localparam logic [7:0] A_C2 = {`IDX_CTRL_TWO, 2'b00};
    localparam logic [7:0] A_S1 = {`IDX_STATUS_ONE, 2'b00};
    localparam logic [7:0] A_C3 = {`IDX_CTRL_THREE, 2'b00};
    localparam logic [7:0] A_EV = {`IDX_EVT_STATUS, 2'b00};
    localparam logic [7:0] A_MK = {`IDX_EVT_MASK, 2'b00};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] pstrb = 4'hF, flags = 4'h0;
    logic busy = 1'b0, tx_ser = 1'b1, wake = 1'b0, send = 1'b0;
    logic shared = 1'b0, txd_line, rxd_line, txd_o, txd_oe;
    logic txd_owned, rxd_owned, rx_serial, qidle, irq, standby;
    logic tx_on, rx_on, brk_on;
    logic [7:0] data = 8'h00, got;
    int n_mismatch = 0, total_checks = 0;

    always #2 clk = ~clk;

    uart_tx_rx_control i_uart_tx_rx_control (.CLK_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .TX_EMPTY_FLAG_I(flags[3]), .TX_COMPLETE_FLAG_I(flags[2]),
        .RX_FULL_FLAG_I(flags[1]), .IDLE_FLAG_I(flags[0]),
        .TX_BUSY_I(busy), .TX_SERIAL_I(tx_ser), .WAKE_EVENT_I(wake),
        .TXD_PIN_I(txd_line), .RXD_PIN_I(rxd_line), .TXD_PIN_O(txd_o),
        .TXD_PIN_OE_O(txd_oe), .TXD_OWNED_O(txd_owned),
        .RXD_OWNED_O(rxd_owned), .RX_SERIAL_O(rx_serial),
        .TX_ENABLE_O(tx_on), .RX_ENABLE_O(rx_on), .RX_STANDBY_O(standby),
        .SEND_BREAK_O(brk_on), .QUEUE_IDLE_O(qidle), .IRQ_O(irq));

    remote_serial #(.BIT_CYC(8)) i_remote_serial (.clk_i(clk),
        .rst_i(rst), .send_i(send), .data_i(data), .shared_i(shared),
        .txd_i(txd_o), .txd_oe_i(txd_oe), .txd_line_o(txd_line),
        .rxd_line_o(rxd_line));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr,
        input logic [31:0] wd, input logic [3:0] strb);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        // The wait ends on pready; only the watchdog ends one that never sees it.
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        check(rdata, {24'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rx_byte(input logic [7:0] d, output logic [7:0] g);
        int n;
        n = 0;
        @(posedge clk);
        send <= 1'b1;
        data <= d;
        @(posedge clk);
        send <= 1'b0;
        while (rx_serial !== 1'b0 && n < 40)
        begin
            cyc(1);
            n++;
        end
        if (n == 40)
            n_mismatch++;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            cyc(8);
            g[i] = rx_serial;
        end
        cyc(24);
    endtask

    task automatic t_regs();
        check({txd_o, txd_oe, irq, rx_serial, rxd_owned}, 5'b10010);
        rd(A_C2, 8'h00);
        wr(A_C2, 8'hF0);
        rd(A_C2, 8'hF0);
        apb(1'b1, A_C2, 32'h0, 4'h0);
        rd(A_C2, 8'hF0);
        apb(1'b0, 8'hFC, 32'h0, 4'hF);
        check({perr, rdata}, {1'b1, 32'h0});
        wr(A_C2, 8'h00);
    endtask

    task automatic t_irq();
        @(posedge clk);
        flags <= 4'hF;
        cyc(3);
        check(irq, 1'b0);
        rd(A_S1, 8'hF0);
        for (int b = 4; b < 8; b++)
        begin
            wr(A_C2, 8'h01 << b);
            cyc(2);
            check(irq, 1'b1);
            @(posedge clk);
            flags <= ~(4'h1 << (b - 4));
            cyc(3);
            check(irq, 1'b0);
            @(posedge clk);
            flags <= 4'hF;
        end
        @(posedge clk);
        flags <= 4'h0;
        wr(A_C2, 8'h00);
    endtask

    task automatic t_wake();
        wr(A_C2, 8'h02);
        cyc(1);
        check(standby, 1'b1);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        cyc(2);
        check({standby, irq}, 2'b00);
        rd(A_EV, 8'h02);
        wr(A_MK, 8'h02);
        cyc(2);
        check(irq, 1'b1);
        wr(A_EV, 8'h02);
        cyc(2);
        check(irq, 1'b0);
        wr(A_MK, 8'h00);
    endtask

    task automatic t_tx();
        int pulses;
        pulses = 0;
        wr(A_C2, 8'h08);
        cyc(2);
        check({tx_on, txd_owned, txd_oe}, 3'b111);
        @(posedge clk);
        tx_ser <= 1'b0;
        cyc(2);
        check(txd_o, 1'b0);
        @(posedge clk);
        tx_ser <= 1'b1;
        busy <= 1'b1;
        wr(A_C2, 8'h00);
        cyc(4);
        check({txd_owned, txd_oe}, 2'b11);
        wr(A_C2, 8'h08);
        // The pulse stands from the write edge to the next edge only.
        for (int i = 0; i < 4; i++)
        begin
            #1;
            pulses += (qidle === 1'b1);
            @(posedge clk);
        end
        check(pulses, 1);
        wr(A_C2, 8'h00);
        cyc(6);
        check(txd_owned, 1'b1);
        wr(A_C2, 8'h01);
        @(posedge clk);
        busy <= 1'b0;
        cyc(4);
        check({brk_on, txd_owned, txd_oe}, 3'b111);
        wr(A_C2, 8'h00);
        cyc(2);
        check({txd_owned, txd_oe}, 2'b00);
        rd(A_EV, 8'h05);
        wr(A_EV, 8'h05);
    endtask

    task automatic t_rx();
        wr(A_C2, 8'h04);
        cyc(1);
        check({rx_on, rxd_owned}, 2'b11);
        rx_byte(8'h5A, got);
        check(got, 8'h5A);
        wr(A_C1, 8'h80);
        cyc(1);
        check(rxd_owned, 1'b0);
        @(posedge clk);
        tx_ser <= 1'b0;
        cyc(3);
        check(rx_serial, 1'b0);
        @(posedge clk);
        tx_ser <= 1'b1;
        wr(A_C1, 8'hA0);
        wr(A_C2, 8'h0C);
        shared <= 1'b1;
        cyc(3);
        check(txd_oe, 1'b0);
        rx_byte(8'hC3, got);
        check(got, 8'hC3);
        wr(A_C3, 8'h20);
        cyc(2);
        check(txd_oe, 1'b1);
        @(posedge clk);
        tx_ser <= 1'b0;
        cyc(6);
        check(rx_serial, 1'b0);
        @(posedge clk);
        tx_ser <= 1'b1;
        shared <= 1'b0;
        wr(A_C1, 8'h00);
        cyc(1);
        check(rxd_owned, 1'b1);
        wr(A_C2, 8'h00);
        cyc(2);
        check({rx_on, rxd_owned}, 2'b00);
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_regs();
        t_irq();
        t_wake();
        t_tx();
        t_rx();
        end_sim();
    end

    // Generous bound: the whole sequence takes about 400 cycles.
    initial
    begin
        #40000;
        n_mismatch++;
        end_sim();
    end
endmodule

`default_nettype wire
